// >>> common/sar_adc_pkg.sv
// Constants and types shared by the SAR converter sequencer
// Summary of operation
// [RULE_01] Each converter gives 8-bit results from 4 channels into four own slots
// [RULE_02] Fixed single: convert chosen channel once, store in its slot, flag done
// [RULE_03] Fixed continuous: rotate results through four slots, flag every fourth
// [RULE_04] Scan single: convert each selected channel once, flag after the last
// [RULE_05] Scan continuous: after flagging, restart at first selected channel until stopped
// [RULE_06] Dual continuous: alternate two channels into slots 0..3, flag per four
// [RULE_07] Single step: convert next selected channel, flag, then wait for a start
// [RULE_08] Timer overflow starts a conversion; overflows during a conversion are ignored
// [RULE_09] Writing immediate start begins a conversion at once in any mode
// [RULE_10] Either edge of the trigger pin starts; edges during conversion are ignored
// [RULE_11] Dual immediate starts both converters; any later trigger starts both
// [RULE_12] Software sets same mode and channel count on both before dual start
// [RULE_13] After four MSBs, compare against limit nibbles; flag boundary when outside
// [RULE_14] If partial compare was inside, compare the full 8-bit result too
// [RULE_15] Clearing boundary enable suppresses every boundary request
// [RULE_16] In DAC mode, slot 3 writes load the DAC, driven onto channel 3 pin
// [RULE_17] Clock divider ratios 1 to 8; software keeps converter clock in range
// [RULE_18] Completion reported by interrupt request and by a pollable status bit
// [RULE_19] Converter keeps running in idle; its completion request wakes the processor
// [RULE_20] In power-down states the converter does not operate
// [RULE_21] SAR resolves one bit per converter clock, MSB first, by comparator
package sar_adc_pkg;
  localparam int          RES_W        = 8;
  localparam int          CH_NUM       = 4;
  localparam int          SLOT_NUM     = 4;
  localparam logic [2:0]  IDX_CTRL     = 3'h0;
  localparam logic [2:0]  IDX_START    = 3'h1;
  localparam logic [2:0]  IDX_STATUS   = 3'h2;
  localparam logic [2:0]  IDX_LIMIT    = 3'h3;
  localparam logic [2:0]  IDX_SLOT0    = 3'h4;
  localparam logic [2:0]  BLK_COMMON   = 3'h4;
  localparam logic [2:0]  IDX_CLKDIV   = 3'h0;
  localparam int          CTRL_MODE    = 0;
  localparam int          CTRL_EN      = 3;
  localparam int          CTRL_IE_DONE = 4;
  localparam int          CTRL_IE_BND  = 5;
  localparam int          CTRL_DAC     = 6;
  localparam int          CTRL_CHA     = 7;
  localparam int          CTRL_CHB     = 9;
  localparam int          CTRL_MASK    = 11;
  localparam int          START_STOP   = 2;
  localparam int          STAT_DONE    = 0;
  localparam int          STAT_BND     = 1;
  localparam int          STAT_BUSY    = 2;
  localparam int          LIMIT_HI     = 8;
  localparam logic [7:0]  LIMIT_HI_RST = 8'hFF;
  localparam logic [7:0]  LIMIT_LO_RST = 8'h00;
  localparam logic [2:0]  CLKDIV_RST   = 3'h0;
  localparam logic [2:0]  SAR_MSB      = 3'h7;
  localparam logic [2:0]  PARTIAL_BIT  = 3'h4;
  localparam logic [7:0]  SAR_FIRST    = 8'h80;
  localparam logic [1:0]  SLOT_LAST    = 2'h3;
  typedef enum logic [2:0] {
    MODE_FIXED_SINGLE, MODE_FIXED_CONT, MODE_SCAN_SINGLE,
    MODE_SCAN_CONT, MODE_DUAL_CONT, MODE_SINGLE_STEP
  } mode_t;
  typedef enum logic [1:0] {SRC_TIMER, SRC_IMMEDIATE, SRC_EDGE, SRC_DUAL} start_src_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONV} conv_state_t;
endpackage : sar_adc_pkg

// >>> hw/sar_adc_sequencer.sv
// Sequencer, SAR logic and APB register file for the multiplexed converters
`timescale 1ns/1ps
module sar_adc_sequencer #(
  parameter int N = 2
) (
  input  wire logic           CORE_CLK_I,
  input  wire logic           RST_B_I,
  input  wire logic           CE_I,
  input  wire logic           PSEL_I,
  input  wire logic           PENABLE_I,
  input  wire logic           PWRITE_I,
  input  wire logic [7:0]     PADDR_I,
  input  wire logic [31:0]    PWDATA_I,
  output logic      [31:0]    PRDATA_O,
  output logic                PREADY_O,
  output logic                PSLVERR_O,
  input  wire logic           TIMER0_OVF_I,
  input  wire logic           EDGE_TRIGGER_PIN_I,
  input  wire logic           POWER_DOWN_I,
  input  wire logic [N-1:0]   COMP_I,
  output logic      [2*N-1:0] CH_SEL_O,
  output logic      [N-1:0]   SAMPLE_O,
  output logic      [8*N-1:0] DAC_CODE_O,
  output logic      [N-1:0]   DAC_PIN_EN_O,
  output logic      [N-1:0]   IRQ_DONE_O,
  output logic      [N-1:0]   IRQ_BOUND_O,
  output logic                WAKE_O
);
  import sar_adc_pkg::*;

  typedef struct packed {
    logic                        pready;
    logic                        pslverr;
    logic [31:0]                 prdata;
    logic [2:0]                  clkdiv;
    logic [2:0]                  div_cnt;
    logic                        pin_prev;
    logic                        wake;
    mode_t       [N-1:0]         mode;
    start_src_t  [N-1:0]         src;
    conv_state_t [N-1:0]         st;
    logic [N-1:0]                en;
    logic [N-1:0]                ie_done;
    logic [N-1:0]                ie_bnd;
    logic [N-1:0]                dacm;
    logic [N-1:0][1:0]           cha;
    logic [N-1:0][1:0]           chb;
    logic [N-1:0][3:0]           mask;
    logic [N-1:0][7:0]           lim_hi;
    logic [N-1:0][7:0]           lim_lo;
    logic [N-1:0]                stop;
    logic [N-1:0]                pend;
    logic [N-1:0]                dflag;
    logic [N-1:0]                bflag;
    logic [N-1:0]                bhit;
    logic [N-1:0][1:0]           ch;
    logic [N-1:0][1:0]           chs;
    logic [N-1:0][1:0]           ptr;
    logic [N-1:0][1:0]           rot;
    logic [N-1:0][2:0]           bitn;
    logic [N-1:0][7:0]           sar;
    logic [N-1:0][SLOT_NUM-1:0][7:0] slot;
    logic [N-1:0]                sample;
    logic [N-1:0][7:0]           dac;
    logic [N-1:0]                dac_en;
    logic [N-1:0]                irq_d;
    logic [N-1:0]                irq_b;
  } state_t;

  state_t q;
  state_t next_q;

  // First selected channel at or after the given one, wrapping round
  function automatic logic [1:0] next_sel(input logic [3:0] m, input logic [1:0] from);
    logic [1:0] k;
    next_sel = from;
    for (int i = 3; i >= 0; i--) begin
      k = from + 2'(i);
      if (m[k]) begin
        next_sel = k;
      end
    end
  endfunction : next_sel

  // True when no selected channel lies above the given one
  function automatic logic last_sel(input logic [3:0] m, input logic [1:0] c);
    last_sel = ((m >> c) >> 1) == 4'h0;
  endfunction : last_sel

  // Limit check on the top nibble or the whole result
  function automatic logic outside(input logic [7:0] v, input logic [7:0] hi,
                                   input logic [7:0] lo, input logic nib);
    if (nib) begin
      outside = (v[7:4] > hi[7:4]) || (v[7:4] < lo[7:4]);
    end else begin
      outside = (v > hi) || (v < lo);
    end
  endfunction : outside

  always_comb begin
    logic          acc;
    logic          wr;
    logic [2:0]    blk;
    logic [2:0]    idx;
    logic          tick;
    logic          edge_ev;
    logic [N-1:0]  raw;
    logic          dual;
    logic          go;
    logic [31:0]   rd;
    logic          mapped;
    logic [7:0]    r;
    logic [1:0]    nch;
    logic [1:0]    sl;
    logic          fin;
    logic          cont;
    next_q  = q;
    acc     = PSEL_I & PENABLE_I & q.pready;
    wr      = acc & PWRITE_I;
    blk     = PADDR_I[7:5];
    idx     = PADDR_I[4:2];
    edge_ev = EDGE_TRIGGER_PIN_I ^ q.pin_prev;
    next_q.pin_prev = EDGE_TRIGGER_PIN_I;
    tick    = (q.div_cnt == q.clkdiv);
    next_q.div_cnt = tick ? 3'h0 : q.div_cnt + 3'h1;                    // [RULE_17]
    rd      = 32'h0000_0000;
    mapped  = 1'b0;
    raw     = '0;
    go      = 1'b0;
    dual    = 1'b0;
    r       = 8'h00;
    nch     = 2'h0;
    sl      = 2'h0;
    fin     = 1'b0;
    cont    = 1'b0;

    // Register read decode
    if (blk == BLK_COMMON && idx == IDX_CLKDIV) begin
      mapped = 1'b1;
      rd     = {29'h0, q.clkdiv};
    end
    for (int c = 0; c < N; c++) begin
      if (blk == 3'(c)) begin
        mapped = 1'b1;
        if (idx == IDX_CTRL) begin
          rd = {17'h0, q.mask[c], q.chb[c], q.cha[c], q.dacm[c], q.ie_bnd[c],
                q.ie_done[c], q.en[c], q.mode[c]};
        end else if (idx == IDX_START) begin
          rd = {29'h0, q.stop[c], q.src[c]};
        end else if (idx == IDX_STATUS) begin
          rd = {29'h0, q.st[c] != ST_IDLE, q.bflag[c], q.dflag[c]};          // [RULE_18]
        end else if (idx == IDX_LIMIT) begin
          rd = {16'h0, q.lim_hi[c], q.lim_lo[c]};
        end else if (idx >= IDX_SLOT0) begin
          rd = {24'h0, q.slot[c][idx[1:0]]};
        end else begin
          mapped = 1'b0;
        end
      end
    end

    // APB answer: one wait state, data and error registered
    next_q.pready = PSEL_I & PENABLE_I & ~q.pready;
    if (PSEL_I & PENABLE_I & ~q.pready) begin
      next_q.prdata  = PWRITE_I ? 32'h0000_0000 : rd;
      next_q.pslverr = ~mapped;
    end else begin
      next_q.pslverr = 1'b0;
    end
    if (wr && blk == BLK_COMMON && idx == IDX_CLKDIV) begin
      next_q.clkdiv = PWDATA_I[2:0];                                        // [RULE_17]
    end

    // Start sources
    for (int c = 0; c < N; c++) begin
      raw[c] = (q.src[c] == SRC_TIMER && TIMER0_OVF_I)                      // [RULE_08]
             | (q.src[c] == SRC_EDGE && edge_ev)                            // [RULE_10]
             | (wr && blk == 3'(c) && idx == IDX_START &&
                (PWDATA_I[1:0] == SRC_IMMEDIATE || PWDATA_I[1:0] == SRC_DUAL)); // [RULE_09]
      dual = dual | (q.src[c] == SRC_DUAL)
           | (wr && blk == 3'(c) && idx == IDX_START && PWDATA_I[1:0] == SRC_DUAL); // [RULE_11]
    end

    for (int c = 0; c < N; c++) begin
      go = dual ? |raw : raw[c];                                            // [RULE_11]
      // Register writes
      if (wr && blk == 3'(c)) begin
        if (idx == IDX_CTRL) begin
          next_q.mode[c]    = mode_t'(PWDATA_I[CTRL_MODE +: 3]);
          next_q.en[c]      = PWDATA_I[CTRL_EN];
          next_q.ie_done[c] = PWDATA_I[CTRL_IE_DONE];
          next_q.ie_bnd[c]  = PWDATA_I[CTRL_IE_BND];
          next_q.dacm[c]    = PWDATA_I[CTRL_DAC];
          next_q.cha[c]     = PWDATA_I[CTRL_CHA +: 2];
          next_q.chb[c]     = PWDATA_I[CTRL_CHB +: 2];
          next_q.mask[c]    = PWDATA_I[CTRL_MASK +: 4];
        end else if (idx == IDX_START) begin
          next_q.src[c] = start_src_t'(PWDATA_I[1:0]);
          if (PWDATA_I[START_STOP]) begin
            next_q.stop[c] = 1'b1;
          end
        end else if (idx == IDX_STATUS) begin
          if (PWDATA_I[STAT_DONE]) begin
            next_q.dflag[c] = 1'b0;
          end
          if (PWDATA_I[STAT_BND]) begin
            next_q.bflag[c] = 1'b0;
          end
        end else if (idx == IDX_LIMIT) begin
          next_q.lim_lo[c] = PWDATA_I[7:0];
          next_q.lim_hi[c] = PWDATA_I[LIMIT_HI +: 8];
        end else if (idx >= IDX_SLOT0) begin
          next_q.slot[c][idx[1:0]] = PWDATA_I[7:0];                         // [RULE_16]
        end
      end

      // Triggers are only caught while idle, so repeats mid-conversion vanish
      if (go && q.st[c] == ST_IDLE && q.en[c]) begin
        next_q.pend[c] = 1'b1;                                              // [RULE_08] [RULE_10]
      end

      if (!q.en[c]) begin
        next_q.st[c]   = ST_IDLE;
        next_q.pend[c] = 1'b0;
        next_q.stop[c] = 1'b0;
      end else if (tick && !POWER_DOWN_I) begin                             // [RULE_19] [RULE_20]
        unique case (q.st[c])
          ST_IDLE: begin
            if (q.pend[c]) begin
              next_q.pend[c] = 1'b0;
              next_q.rot[c]  = 2'h0;
              next_q.stop[c] = 1'b0;
              next_q.st[c]   = ST_SAMPLE;
              unique case (q.mode[c])
                MODE_SCAN_SINGLE, MODE_SCAN_CONT: next_q.ch[c] = next_sel(q.mask[c], 2'h0);
                MODE_SINGLE_STEP: next_q.ch[c] = next_sel(q.mask[c], q.ptr[c]);  // [RULE_07]
                default:          next_q.ch[c] = q.cha[c];
              endcase
            end
          end
          ST_SAMPLE: begin
            next_q.st[c]   = ST_CONV;
            next_q.bitn[c] = SAR_MSB;
            next_q.sar[c]  = SAR_FIRST;                                     // [RULE_21]
            next_q.bhit[c] = 1'b0;
          end
          ST_CONV: begin
            r = q.sar[c];
            if (!COMP_I[c]) begin
              r[q.bitn[c]] = 1'b0;                                          // [RULE_21]
            end
            if (q.bitn[c] != 3'h0) begin
              r[q.bitn[c] - 3'h1] = 1'b1;
            end
            next_q.sar[c] = r;
            if (q.bitn[c] == PARTIAL_BIT && outside(r, q.lim_hi[c], q.lim_lo[c], 1'b1)) begin
              next_q.bflag[c] = 1'b1;                                       // [RULE_13]
              next_q.bhit[c]  = 1'b1;
            end
            if (q.bitn[c] != 3'h0) begin
              next_q.bitn[c] = q.bitn[c] - 3'h1;
            end else begin
              if (!q.bhit[c] && outside(r, q.lim_hi[c], q.lim_lo[c], 1'b0)) begin
                next_q.bflag[c] = 1'b1;                                     // [RULE_14]
              end
              nch  = q.ch[c];
              sl   = q.ch[c];
              fin  = 1'b1;
              cont = 1'b0;
              unique case (q.mode[c])
                MODE_FIXED_CONT: begin
                  sl   = q.rot[c];                                          // [RULE_03]
                  fin  = q.rot[c] == SLOT_LAST;
                  cont = 1'b1;
                end
                MODE_SCAN_SINGLE: begin
                  fin  = last_sel(q.mask[c], q.ch[c]);                      // [RULE_04]
                  cont = ~fin;
                  nch  = next_sel(q.mask[c], q.ch[c] + 2'h1);
                end
                MODE_SCAN_CONT: begin
                  fin  = last_sel(q.mask[c], q.ch[c]);                      // [RULE_05]
                  cont = 1'b1;
                  nch  = next_sel(q.mask[c], q.ch[c] + 2'h1);
                end
                MODE_DUAL_CONT: begin
                  sl   = q.rot[c];                                          // [RULE_06]
                  fin  = q.rot[c] == SLOT_LAST;
                  cont = 1'b1;
                  nch  = q.rot[c][0] ? q.cha[c] : q.chb[c];
                end
                MODE_SINGLE_STEP: begin
                  next_q.ptr[c] = next_sel(q.mask[c], q.ch[c] + 2'h1);      // [RULE_07]
                end
                default: begin
                  fin = 1'b1;                                               // [RULE_02]
                end
              endcase
              next_q.slot[c][sl] = r;                                       // [RULE_01]
              next_q.rot[c]      = q.rot[c] + 2'h1;
              if (fin) begin
                next_q.dflag[c] = 1'b1;                                     // [RULE_18]
              end
              if (cont && !q.stop[c] && !next_q.stop[c]) begin
                next_q.st[c] = ST_SAMPLE;
                next_q.ch[c] = nch;
              end else begin
                next_q.st[c]   = ST_IDLE;
                next_q.stop[c] = 1'b0;
              end
            end
          end
        endcase
      end

      // Registered outputs
      next_q.sample[c] = next_q.st[c] == ST_SAMPLE;
      next_q.dac_en[c] = next_q.dacm[c] && next_q.st[c] == ST_IDLE;       // [RULE_16]
      next_q.chs[c]    = next_q.dac_en[c] ? SLOT_LAST : next_q.ch[c];
      next_q.dac[c]    = next_q.dac_en[c] ? next_q.slot[c][SLOT_LAST] : next_q.sar[c];
      next_q.irq_d[c]  = next_q.dflag[c] & next_q.ie_done[c];               // [RULE_18]
      next_q.irq_b[c]  = next_q.bflag[c] & next_q.ie_bnd[c];                // [RULE_15]
    end
    next_q.wake = |next_q.irq_d;                                            // [RULE_19]
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      q        <= '0;
      q.clkdiv <= CLKDIV_RST;
      for (int c = 0; c < N; c++) begin
        q.lim_hi[c] <= LIMIT_HI_RST;
        q.lim_lo[c] <= LIMIT_LO_RST;
      end
    end else if (CE_I) begin
      q <= next_q;
    end
  end

  always_comb begin
    for (int c = 0; c < N; c++) begin
      CH_SEL_O[2*c +: 2]   = q.chs[c];
      DAC_CODE_O[8*c +: 8] = q.dac[c];
    end
  end

  assign PRDATA_O     = q.prdata;
  assign PREADY_O     = q.pready;
  assign PSLVERR_O    = q.pslverr;
  assign SAMPLE_O     = q.sample;
  assign DAC_PIN_EN_O = q.dac_en;
  assign IRQ_DONE_O   = q.irq_d;
  assign IRQ_BOUND_O  = q.irq_b;
  assign WAKE_O       = q.wake;
endmodule : sar_adc_sequencer

// >>> verification/sar_adc_front.sv
// Behavioural input multiplexer, sample-and-hold and comparator per converter
`timescale 1ns/1ps
module sar_adc_front #(
  parameter int N = 2
) (
  input  wire logic                   clk_i,
  input  wire logic [N-1:0][3:0][7:0] level_i,
  input  wire logic [2*N-1:0]         ch_sel_i,
  input  wire logic [N-1:0]           sample_i,
  input  wire logic [8*N-1:0]         dac_code_i,
  output logic      [N-1:0]           comp_o
);
  logic [N-1:0][7:0] held;
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < N; c++) begin
      if (sample_i[c]) begin
        held[c] <= level_i[c][ch_sel_i[2*c+:2]];
      end
    end
  end
  always_comb begin
    for (int c = 0; c < N; c++) begin
      comp_o[c] = held[c] >= dac_code_i[8*c+:8];
    end
  end
endmodule : sar_adc_front

// >>> verification/sar_adc_sequencer_props.sv
// Port-level assertions for the converter sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_props #(
  parameter int N = 2
) (
  input wire logic           CORE_CLK_I,
  input wire logic           RST_B_I,
  input wire logic           CE_I,
  input wire logic           PSEL_I,
  input wire logic           PENABLE_I,
  input wire logic           PWRITE_I,
  input wire logic [7:0]     PADDR_I,
  input wire logic [31:0]    PWDATA_I,
  input wire logic [31:0]    PRDATA_O,
  input wire logic           PREADY_O,
  input wire logic           PSLVERR_O,
  input wire logic           TIMER0_OVF_I,
  input wire logic           EDGE_TRIGGER_PIN_I,
  input wire logic           POWER_DOWN_I,
  input wire logic [N-1:0]   COMP_I,
  input wire logic [2*N-1:0] CH_SEL_O,
  input wire logic [N-1:0]   SAMPLE_O,
  input wire logic [8*N-1:0] DAC_CODE_O,
  input wire logic [N-1:0]   DAC_PIN_EN_O,
  input wire logic [N-1:0]   IRQ_DONE_O,
  input wire logic [N-1:0]   IRQ_BOUND_O,
  input wire logic           WAKE_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  wake_follows_done_a: assert property (WAKE_O == (|IRQ_DONE_O))
    else $error("wake differs from done requests");
  apb_one_wait_a: assert property ((PSEL_I && !PENABLE_I && CE_I) ##1
    (PSEL_I && PENABLE_I && CE_I) |=> PREADY_O) else $error("ready not on second access");
  ready_pulse_a: assert property ($rose(PREADY_O) |-> $past(PSEL_I && PENABLE_I) ##1 !PREADY_O)
    else $error("ready without request or too long");
  refused_read_a: assert property (PSLVERR_O |-> PREADY_O && (PWRITE_I || PRDATA_O == 32'h0))
    else $error("error answer malformed");
  dac_pin_idle_a: assert property (DAC_PIN_EN_O[0] |-> CH_SEL_O[1:0] == 2'h3 && !SAMPLE_O[0])
    else $error("dac pin driven while converting");
  pd_freeze_a: assert property ($past(POWER_DOWN_I && !PSEL_I) |->
    $stable(SAMPLE_O) && $stable(DAC_CODE_O) && $stable(IRQ_DONE_O)) else $error("ran in power-down");
  ce_freeze_a: assert property (!CE_I |=> $stable(PREADY_O) && $stable(PRDATA_O) && $stable(DAC_CODE_O))
    else $error("state moved without clock enable");
  sar_msb_first_a: assert property ($fell(SAMPLE_O[0]) |-> ##[0:8] DAC_CODE_O[7:0] == 8'h80)
    else $error("first trial code not msb");
  cover property ($rose(IRQ_DONE_O[0]));
  cover property ($rose(IRQ_BOUND_O[0]));
  cover property (DAC_PIN_EN_O[0]);
  cover property (&SAMPLE_O);
endmodule : sar_adc_sequencer_props

bind sar_adc_sequencer sar_adc_sequencer_props #(.N(N)) u_props (
  .CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .CE_I(CE_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TIMER0_OVF_I(TIMER0_OVF_I),
  .EDGE_TRIGGER_PIN_I(EDGE_TRIGGER_PIN_I), .POWER_DOWN_I(POWER_DOWN_I), .COMP_I(COMP_I),
  .CH_SEL_O(CH_SEL_O), .SAMPLE_O(SAMPLE_O), .DAC_CODE_O(DAC_CODE_O), .DAC_PIN_EN_O(DAC_PIN_EN_O),
  .IRQ_DONE_O(IRQ_DONE_O), .IRQ_BOUND_O(IRQ_BOUND_O), .WAKE_O(WAKE_O));

// >>> verification/sar_adc_sequencer_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_tb;
  import sar_adc_pkg::*;
  localparam int              N    = 2;
  localparam logic [7:0]      FILL = 8'hC3;
  localparam logic [2:0][7:0] BV   = {8'h47, 8'h4C, 8'h90};
  localparam logic [2:0][7:0] BLO  = {8'h45, 8'h45, 8'h40};
  localparam logic [2:0][7:0] BHI  = {8'h4A, 8'h4A, 8'h7F};
  localparam logic [2:0]      BX   = 3'h3;
  logic                   clk, rst_b, ce, psel, penable, pwrite, tovf, epin, pdn, erv;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, rdv, prdata;
  logic [3:0]             mk;
  logic [N-1:0][3:0][7:0] lvl;
  logic                   pready, pslverr, wake;
  logic [N-1:0]           comp, sample, dac_en, irq_done, irq_bnd;
  logic [2*N-1:0]         ch_sel;
  logic [8*N-1:0]         dac_code;
  int                     err_count, checks, seed, cyc, c, ca, cb, d;
  sar_adc_sequencer #(.N(N)) u_sar_adc_sequencer (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .TIMER0_OVF_I(tovf), .EDGE_TRIGGER_PIN_I(epin),
    .POWER_DOWN_I(pdn), .COMP_I(comp), .CH_SEL_O(ch_sel), .SAMPLE_O(sample),
    .DAC_CODE_O(dac_code), .DAC_PIN_EN_O(dac_en), .IRQ_DONE_O(irq_done),
    .IRQ_BOUND_O(irq_bnd), .WAKE_O(wake));
  sar_adc_front #(.N(N)) u_sar_adc_front (.clk_i(clk), .level_i(lvl), .ch_sel_i(ch_sel),
    .sample_i(sample), .dac_code_i(dac_code), .comp_o(comp));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic wrap_up;
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask : cmp
  task automatic hang(input string nm);
    err_count++;
    $display("BAD %s expected answer seen timeout", nm);
    wrap_up();
  endtask : hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) hang("pready");
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  function automatic logic [7:0] ad(input int k, input logic [2:0] i);
    return {k[2:0], i, 2'b00};
  endfunction : ad
  function automatic logic [31:0] ctl(input int m, ie, a, b, input logic [3:0] msk);
    return 32'(m) | (32'h1 << CTRL_EN) | (32'(ie) << CTRL_IE_DONE) | (32'(a) << CTRL_CHA)
      | (32'(b) << CTRL_CHB) | (32'(msk) << CTRL_MASK);
  endfunction : ctl
  function automatic logic [7:0] exp_slot(input int k, m, s, a, b, input logic [3:0] msk);
    int f;
    f = 0;
    while (f < 3 && !msk[f]) f++;
    case (m)
      0: return (s == a) ? lvl[k][a] : FILL;
      1: return lvl[k][a];
      2, 3: return msk[s] ? lvl[k][s] : FILL;
      4: return lvl[k][(s % 2) ? b : a];
      default: return (s == f) ? lvl[k][f] : FILL;
    endcase
  endfunction : exp_slot
  task automatic wait_irq(input int k);
    cyc = 0;
    while (irq_done[k] !== 1'b1) begin
      @(posedge clk);
      cyc++;
      if (cyc > 3000) hang("done");
    end
  endtask : wait_irq
  task automatic idle(input int k);
    int n;
    n = 0;
    do begin
      rd(ad(k, IDX_STATUS));
      n++;
    end while (rdv[STAT_BUSY] !== 1'b0 && n < 100);
    if (n >= 100) hang("busy");
  endtask : idle
  task automatic fire(input int t);
    @(posedge clk);
    if (t == 1) epin <= ~epin;
    else tovf <= 1'b1;
    @(posedge clk);
    tovf <= 1'b0;
  endtask : fire
  initial begin
    seed = 32'h79021313;
    {err_count, checks} = 0;
    {rst_b, psel, penable, pwrite, tovf, epin, pdn, paddr, pwdata} = '0;
    ce = 1'b1;
    for (int i = 0; i < 8; i++) lvl[i/4][i%4] = 8'($random(seed));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(ad(0, IDX_LIMIT));
    cmp("limit", {16'h0, LIMIT_HI_RST, LIMIT_LO_RST}, rdv);
    rd(8'hA0);
    cmp("unmapped", 32'h1, {rdv[30:0], erv});
    for (int m = 0; m < 6; m++) begin
      c = m % 2;
      d = $random(seed) & 7;
      ca = $random(seed) & 3;
      cb = $random(seed) & 3;
      mk = 4'($random(seed));
      if (mk == 4'h0) mk = 4'h9;
      wr({BLK_COMMON, IDX_CLKDIV, 2'b00}, 32'(d));
      for (int s = 0; s < 4; s++) wr(ad(c, IDX_SLOT0 + 3'(s)), 32'(FILL));
      wr(ad(c, IDX_CTRL), ctl(m, 1, ca, cb, mk));
      wr(ad(c, IDX_START), 32'h1);
      wait_irq(c);
      if (m == 0) cmp("time", 1, 32'(cyc >= 8*(d+1) && cyc <= 12*(d+1)+4));
      cmp("wake", 1, 32'(wake));
      wr(ad(c, IDX_START), 32'h4);
      idle(c);
      for (int s = 0; s < 4; s++) begin
        rd(ad(c, IDX_SLOT0 + 3'(s)));
        cmp("slot", 32'(exp_slot(c, m, s, ca, cb, mk)), rdv);
      end
      rd(ad(c, IDX_STATUS));
      cmp("done flag", 1, 32'(rdv[STAT_DONE]));
      wr(ad(c, IDX_STATUS), 32'h3);
      wr(ad(c, IDX_CTRL), 32'h0);
    end
    wr({BLK_COMMON, IDX_CLKDIV, 2'b00}, 32'h0);
    for (int t = 0; t < 2; t++) begin
      wr(ad(0, IDX_CTRL), ctl(0, 1, 2, 0, 4'h0));
      wr(ad(0, IDX_START), t ? 32'h2 : 32'h0);
      fire(t);
      repeat (2) @(posedge clk);
      fire(t);
      wait_irq(0);
      wr(ad(0, IDX_STATUS), 32'h3);
      repeat (30) @(posedge clk);
      cmp("extra start", 0, 32'(irq_done[0]));
    end
    wr(ad(0, IDX_START), 32'h1);
    pdn <= 1'b1;
    repeat (40) @(posedge clk);
    cmp("power-down done", 0, 32'(irq_done[0]));
    pdn <= 1'b0;
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    wait_irq(0);
    wr(ad(0, IDX_STATUS), 32'h3);
    for (int k = 0; k < 2; k++) wr(ad(k, IDX_CTRL), ctl(0, 1, 1, 0, 4'h0));
    wr(ad(0, IDX_START), 32'h3);
    wait_irq(0);
    wait_irq(1);
    wr(ad(0, IDX_STATUS), 32'h3);
    wr(ad(1, IDX_STATUS), 32'h3);
    wr(ad(1, IDX_START), 32'h1);
    wait_irq(0);
    cmp("dual done", 1, 32'(irq_done[1]));
    rd(ad(1, IDX_SLOT0 + 3'h1));
    cmp("dual slot", 32'(lvl[1][1]), rdv);
    for (int b = 0; b < 3; b++) begin
      lvl[0][0] <= BV[b];
      wr(ad(0, IDX_STATUS), 32'h3);
      wr(ad(0, IDX_LIMIT), {16'h0, BHI[b], BLO[b]});
      wr(ad(0, IDX_CTRL), ctl(0, 3, 0, 0, 4'h0));
      wr(ad(0, IDX_START), 32'h1);
      wait_irq(0);
      repeat (2) @(posedge clk);
      cmp("bound irq", 32'(BX[b]), 32'(irq_bnd[0]));
      wr(ad(0, IDX_CTRL), ctl(0, 1, 0, 0, 4'h0));
      repeat (2) @(posedge clk);
      cmp("bound off", 0, 32'(irq_bnd[0]));
    end
    wr(ad(0, IDX_CTRL), ctl(0, 4, 0, 0, 4'h0));
    d = $random(seed) & 255;
    wr(ad(0, IDX_SLOT0 + 3'h3), 32'(d));
    repeat (2) @(posedge clk);
    cmp("dac", {22'h1, 2'h3, 8'(d)}, {21'h0, dac_en[0], ch_sel[1:0], dac_code[7:0]});
    wrap_up();
  end
endmodule : sar_adc_sequencer_tb
